//--- rtl/dafmt_pkg.sv
// Constants and types for the dual-channel sample output formatter
package dafmt_pkg;
    localparam int          SAMPLE_W      = 14;
    localparam int          PAIR_W        = 7;
    localparam int          PIPE_DEPTH    = 3;
    localparam int          PHASE_W       = 2;
    localparam int          CURR_W        = 3;
    localparam int          EVT_W         = 3;
    // Register offsets (byte addresses)
    localparam logic [7:0]  OFF_CTRL      = 8'h00;
    localparam logic [7:0]  OFF_STATUS    = 8'h04;
    localparam logic [7:0]  OFF_IRQ_STAT  = 8'h08;
    localparam logic [7:0]  OFF_IRQ_MASK  = 8'h0C;
    // Control field positions
    localparam int          CTRL_MODE_LSB = 0;
    localparam int          CTRL_PH_LSB   = 2;
    localparam int          CTRL_TERM_BIT = 4;
    localparam int          CTRL_CUR_LSB  = 5;
    // Event bit positions
    localparam int          EVT_OVR_A     = 0;
    localparam int          EVT_OVR_B     = 1;
    localparam int          EVT_SAMPLE    = 2;
    // Reset values
    localparam logic [1:0]  MODE_RST      = 2'h0;
    localparam logic [1:0]  PHASE_RST     = 2'h0;
    localparam logic [2:0]  CURR_RST      = 3'h4;
    localparam logic [2:0]  MASK_RST      = 3'h0;

    typedef enum logic [1:0] {
        DAFMT_FULL_CMOS,
        DAFMT_DDR_CMOS,
        DAFMT_DDR_LVDS
    } dafmt_mode_e;
endpackage

//--- rtl/dafmt_top.sv
// Dual-channel sample output formatter with register port
// Summary of operation
// - Full-rate data and range flags change as the true clock falls.
// - In DDR modes data and flags change on both true clock edges.
// - The complementary clock is always the inverse of the true clock.
// - The true clock may be delayed against the data by a set amount.
// - In full-rate mode each channel has its own 14-bit word, bit 13 MSB.
// - In full-rate mode each channel has a flag, high when out of range.
// - DDR: seven lines per channel, even bits clock low, odd bits high.
// - DDR: one shared flag, channel b while clock low, a while high.
// - In DDR LVDS mode an internal termination is switched by a setting.
// - In DDR LVDS mode the drive current is chosen by a setting.
// - Both channels are captured at one instant from one encode source.
// - Range flags pass the same pipeline depth as their data.
// - Mode from a register, or a pin in parallel mode without DDR CMOS.
// - A new conversion starts on each rising edge of the encode input.
//
// Implementation choices: the address map and strobed register access.
`timescale 1ns/100ps
module dafmt_top (
    input  wire logic                  ref_clk,
    input  wire logic                  sys_rst,
    input  wire logic                  sample_strobe_true,
    input  wire logic [13:0]           conv_ch_a,
    input  wire logic [13:0]           conv_ch_b,
    input  wire logic                  range_ch_a,
    input  wire logic                  range_ch_b,
    input  wire logic                  par_prog_mode,
    input  wire logic                  par_mode_pin,
    input  wire logic [7:0]            reg_addr,
    input  wire logic [31:0]           reg_wdata,
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    output logic [31:0]                reg_rdata,
    output logic                       irq,
    output logic                       fwd_clock_true,
    output logic                       fwd_clock_comp,
    output logic [13:0]                sample_bits_ch_a,
    output logic [13:0]                sample_bits_ch_b,
    output logic                       range_flag_ch_a,
    output logic                       range_flag_ch_b,
    output logic [6:0]                 paired_bits_ch_a,
    output logic [6:0]                 paired_bits_ch_b,
    output logic                       range_flag_shared,
    output logic                       lvds_term_en,
    output logic [2:0]                 lvds_current
);
    typedef struct packed {
        logic [2:0]  enc_sync;
        logic [1:0]  par_meta;
        logic [1:0]  par_sync;
        logic [dafmt_pkg::PIPE_DEPTH-1:0][13:0] pipe_a;
        logic [dafmt_pkg::PIPE_DEPTH-1:0][13:0] pipe_b;
        logic [dafmt_pkg::PIPE_DEPTH-1:0] pov_a;
        logic [dafmt_pkg::PIPE_DEPTH-1:0] pov_b;
        logic [13:0] word_a;
        logic [13:0] word_b;
        logic        ov_a;
        logic        ov_b;
        logic        phase;
        logic [3:0]  clk_dly;
        logic [1:0]  ctrl_mode;
        logic [1:0]  ctrl_phase;
        logic        ctrl_term;
        logic [2:0]  ctrl_cur;
        logic [2:0]  ev_stat;
        logic [2:0]  ev_mask;
        logic [31:0] rdata;
        logic        irq;
        logic        clk_t;
        logic        clk_c;
        logic [13:0] out_a;
        logic [13:0] out_b;
        logic        of_a;
        logic        of_b;
        logic [6:0]  dp_a;
        logic [6:0]  dp_b;
        logic        of_sh;
        logic        term;
        logic [2:0]  cur;
    } dafmt_state_s;

    dafmt_state_s st_reg;
    dafmt_state_s st_next;

    function automatic logic [6:0] dafmt_pick(input logic [13:0] w,
                                             input logic odd);
        logic [6:0] r;
        r = '0;
        for (int i = 0; i < dafmt_pkg::PAIR_W; i++) begin
            r[i] = w[2*i + (odd ? 1 : 0)];
        end
        return r;
    endfunction

    dafmt_pkg::dafmt_mode_e mode_eff;
    logic                   enc_rise;
    logic [2:0]             ev_set;
    logic [13:0]            tail_a;
    logic [13:0]            tail_b;
    logic                   tail_fa;
    logic                   tail_fb;

    always_comb begin
        // Parallel mode takes the pin: low full CMOS, high DDR LVDS
        if (st_reg.par_sync[1]) begin
            mode_eff = st_reg.par_sync[0] ? dafmt_pkg::DAFMT_DDR_LVDS
                                          : dafmt_pkg::DAFMT_FULL_CMOS;
        end else begin
            unique case (st_reg.ctrl_mode)
                2'h1:    mode_eff = dafmt_pkg::DAFMT_DDR_CMOS;
                2'h2:    mode_eff = dafmt_pkg::DAFMT_DDR_LVDS;
                default: mode_eff = dafmt_pkg::DAFMT_FULL_CMOS;
            endcase
        end
    end

    assign enc_rise = st_reg.enc_sync[1] & ~st_reg.enc_sync[2];
    assign tail_a   = st_reg.pipe_a[dafmt_pkg::PIPE_DEPTH-1];
    assign tail_b   = st_reg.pipe_b[dafmt_pkg::PIPE_DEPTH-1];
    assign tail_fa  = st_reg.pov_a[dafmt_pkg::PIPE_DEPTH-1];
    assign tail_fb  = st_reg.pov_b[dafmt_pkg::PIPE_DEPTH-1];

    always_comb begin
        logic        nph;
        logic        ddr;
        logic        shifted;
        nph = 1'b0;
        ddr = 1'b0;
        shifted = 1'b0;
        st_next = st_reg;
        ev_set = '0;
        st_next.enc_sync = {st_reg.enc_sync[1:0], sample_strobe_true};
        // Pin levels into a pair of flops each
        st_next.par_meta = {par_prog_mode, par_mode_pin};
        st_next.par_sync = st_reg.par_meta;
        // One shared capture for both channels
        if (enc_rise) begin
            st_next.pipe_a[0] = conv_ch_a;
            st_next.pipe_b[0] = conv_ch_b;
            st_next.pov_a[0]  = range_ch_a;
            st_next.pov_b[0]  = range_ch_b;
            for (int i = 1; i < dafmt_pkg::PIPE_DEPTH; i++) begin
                st_next.pipe_a[i] = st_reg.pipe_a[i-1];
                st_next.pipe_b[i] = st_reg.pipe_b[i-1];
                st_next.pov_a[i]  = st_reg.pov_a[i-1];
                st_next.pov_b[i]  = st_reg.pov_b[i-1];
            end
            st_next.word_a = st_reg.pipe_a[dafmt_pkg::PIPE_DEPTH-1];
            st_next.word_b = st_reg.pipe_b[dafmt_pkg::PIPE_DEPTH-1];
            st_next.ov_a = st_reg.pov_a[dafmt_pkg::PIPE_DEPTH-1];
            st_next.ov_b = st_reg.pov_b[dafmt_pkg::PIPE_DEPTH-1];
            ev_set[dafmt_pkg::EVT_SAMPLE] = 1'b1;
            ev_set[dafmt_pkg::EVT_OVR_A] = tail_fa;
            ev_set[dafmt_pkg::EVT_OVR_B] = tail_fb;
        end
        // Output phase: low half after each capture, high after
        nph = st_reg.phase;
        if (enc_rise) begin
            nph = 1'b0;
        end else if (st_reg.enc_sync[2] & ~st_reg.enc_sync[1]) begin
            nph = 1'b1;
        end
        st_next.phase = nph;
        ddr = (mode_eff != dafmt_pkg::DAFMT_FULL_CMOS);
        if (enc_rise) begin
            // Full-rate: new word with the clock falling
            st_next.out_a = tail_a;
            st_next.out_b = tail_b;
            st_next.of_a = tail_fa;
            st_next.of_b = tail_fb;
        end
        if (ddr) begin
            // Low half even bits and channel b flag, high odd and channel a
            st_next.dp_a = dafmt_pick(enc_rise ? tail_a : st_reg.word_a,
                                      nph);
            st_next.dp_b = dafmt_pick(enc_rise ? tail_b : st_reg.word_b,
                                      nph);
            st_next.of_sh = nph ? (enc_rise ? tail_fa : st_reg.ov_a)
                : (enc_rise ? tail_fb : st_reg.ov_b);
        end else begin
            st_next.dp_a = '0;
            st_next.dp_b = '0;
            st_next.of_sh = 1'b0;
        end
        // Programmable clock delay in ref_clk cycles
        st_next.clk_dly = {st_reg.clk_dly[2:0], nph};
        shifted = (st_reg.ctrl_phase == 2'h0) ? nph
                  : st_next.clk_dly[st_reg.ctrl_phase];
        st_next.clk_t = shifted;
        st_next.clk_c = ~shifted;
        st_next.term = (mode_eff == dafmt_pkg::DAFMT_DDR_LVDS)
                       & st_reg.ctrl_term;
        st_next.cur  = st_reg.ctrl_cur;
        // Register writes; set wins over clear
        if (reg_wr) begin
            unique case (reg_addr)
                dafmt_pkg::OFF_CTRL: begin
                    st_next.ctrl_mode  = reg_wdata[dafmt_pkg::CTRL_MODE_LSB +: 2];
                    st_next.ctrl_phase = reg_wdata[dafmt_pkg::CTRL_PH_LSB +: 2];
                    st_next.ctrl_term  = reg_wdata[dafmt_pkg::CTRL_TERM_BIT];
                    st_next.ctrl_cur   = reg_wdata[dafmt_pkg::CTRL_CUR_LSB +: 3];
                end
                dafmt_pkg::OFF_IRQ_STAT: begin
                    st_next.ev_stat = st_reg.ev_stat & ~reg_wdata[2:0];
                end
                dafmt_pkg::OFF_IRQ_MASK: begin
                    st_next.ev_mask = reg_wdata[2:0];
                end
                default: begin
                end
            endcase
        end
        st_next.ev_stat = st_next.ev_stat | ev_set;
        st_next.irq = |(st_next.ev_stat & st_next.ev_mask);
        st_next.rdata = '0;
        if (reg_rd) begin
            unique case (reg_addr)
                dafmt_pkg::OFF_CTRL: st_next.rdata = {24'h000000,
                    st_reg.ctrl_cur, st_reg.ctrl_term,
                    st_reg.ctrl_phase, st_reg.ctrl_mode};
                dafmt_pkg::OFF_STATUS: st_next.rdata = {29'h00000000,
                    st_reg.par_sync[1], mode_eff};
                dafmt_pkg::OFF_IRQ_STAT: st_next.rdata = {29'h00000000,
                    st_reg.ev_stat};
                dafmt_pkg::OFF_IRQ_MASK: st_next.rdata = {29'h00000000,
                    st_reg.ev_mask};
                default: st_next.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_reg            <= '0;
            st_reg.ctrl_mode  <= dafmt_pkg::MODE_RST;
            st_reg.ctrl_phase <= dafmt_pkg::PHASE_RST;
            st_reg.ctrl_cur   <= dafmt_pkg::CURR_RST;
            st_reg.cur        <= dafmt_pkg::CURR_RST;
            st_reg.ev_mask    <= dafmt_pkg::MASK_RST;
            st_reg.clk_c      <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign reg_rdata         = st_reg.rdata;
    assign irq               = st_reg.irq;
    assign fwd_clock_true    = st_reg.clk_t;
    assign fwd_clock_comp    = st_reg.clk_c;
    assign sample_bits_ch_a  = st_reg.out_a;
    assign sample_bits_ch_b  = st_reg.out_b;
    assign range_flag_ch_a   = st_reg.of_a;
    assign range_flag_ch_b   = st_reg.of_b;
    assign paired_bits_ch_a  = st_reg.dp_a;
    assign paired_bits_ch_b  = st_reg.dp_b;
    assign range_flag_shared = st_reg.of_sh;
    assign lvds_term_en      = st_reg.term;
    assign lvds_current      = st_reg.cur;

    property p_comp_inverse;
        @(posedge ref_clk) disable iff (sys_rst)
        fwd_clock_comp == ~fwd_clock_true;
    endproperty
    a_comp_inverse: assert property (p_comp_inverse)
        else $error("complementary clock not inverse");

    property p_pair_capture;
        @(posedge ref_clk) disable iff (sys_rst)
        enc_rise |=> (st_reg.pipe_a[0] == $past(conv_ch_a)
                      && st_reg.pipe_b[0] == $past(conv_ch_b));
    endproperty
    a_pair_capture: assert property (p_pair_capture)
        else $error("channels not captured together");

    property p_flag_follows;
        @(posedge ref_clk) disable iff (sys_rst)
        enc_rise |=> st_reg.ov_a == $past(st_reg.pov_a[2]);
    endproperty
    a_flag_follows: assert property (p_flag_follows)
        else $error("flag pipeline mismatch");

    property p_no_ddr_cmos_par;
        @(posedge ref_clk) disable iff (sys_rst)
        st_reg.par_sync[1] |-> mode_eff != dafmt_pkg::DAFMT_DDR_CMOS;
    endproperty
    a_no_ddr_cmos_par: assert property (p_no_ddr_cmos_par)
        else $error("ddr cmos selected in parallel mode");

    property p_full_hold;
        @(posedge ref_clk) disable iff (sys_rst)
        !enc_rise |=> $stable(sample_bits_ch_a);
    endproperty
    a_full_hold: assert property (p_full_hold)
        else $error("full-rate word changed off edge");

    property p_term_lvds;
        @(posedge ref_clk) disable iff (sys_rst)
        lvds_term_en |-> $past(mode_eff) == dafmt_pkg::DAFMT_DDR_LVDS;
    endproperty
    a_term_lvds: assert property (p_term_lvds)
        else $error("termination outside lvds mode");

    property p_irq_level;
        @(posedge ref_clk) disable iff (sys_rst)
        irq == |(st_reg.ev_stat & st_reg.ev_mask);
    endproperty
    a_irq_level: assert property (p_irq_level)
        else $error("irq not matching status");

    property p_cur_follow;
        @(posedge ref_clk) disable iff (sys_rst)
        lvds_current == $past(st_reg.ctrl_cur);
    endproperty
    a_cur_follow: assert property (p_cur_follow)
        else $error("drive current not applied");

    c_sample: cover property (@(posedge ref_clk) enc_rise);
    c_ddr: cover property (@(posedge ref_clk)
        mode_eff == dafmt_pkg::DAFMT_DDR_LVDS && enc_rise);
    c_irq: cover property (@(posedge ref_clk) irq);
endmodule

//--- tb/dafmt_rx_model.sv
// Receiver model latching formatter output on the forwarded clock
`timescale 1ns/100ps
module dafmt_rx_model (
    input  wire logic        ref_clk,
    input  wire logic        ddr,
    input  wire logic        fwd_clock_true,
    input  wire logic [13:0] sample_bits_ch_a,
    input  wire logic [13:0] sample_bits_ch_b,
    input  wire logic        range_flag_ch_a,
    input  wire logic        range_flag_ch_b,
    input  wire logic [6:0]  paired_bits_ch_a,
    input  wire logic [6:0]  paired_bits_ch_b,
    input  wire logic        range_flag_shared
);
    logic        clk_q = 1'b0;
    logic        pend = 1'b0;
    logic [13:0] data_q = 14'h0;
    logic [6:0]  even_a, even_b;
    logic [13:0] word_a, word_b;
    logic        flag_a, flag_b;
    int          cnt = 0;
    int          lag = 0;
    wire         rise = !clk_q && fwd_clock_true;
    wire         fall = clk_q && !fwd_clock_true;
    wire         chg = sample_bits_ch_a != data_q;

    function automatic logic [13:0] weave(input logic [6:0] e, o);
        for (int i = 0; i < 7; i++) begin
            weave[2*i] = e[i];
            weave[2*i+1] = o[i];
        end
    endfunction

    // Cycles from a data change to the next falling clock edge
    always_ff @(posedge ref_clk) begin
        clk_q <= fwd_clock_true;
        data_q <= sample_bits_ch_a;
        cnt <= chg ? 0 : cnt + 1;
        if (fall && (pend || chg)) begin
            lag <= chg ? 0 : cnt + 1;
        end
        pend <= (pend || chg) && !fall;
    end

    // Latch words: full rate on rise, pairs over both phases
    always_ff @(posedge ref_clk) begin
        if (fall && ddr) begin
            even_a <= paired_bits_ch_a;
            even_b <= paired_bits_ch_b;
            flag_b <= range_flag_shared;
        end
        if (rise && ddr) begin
            word_a <= weave(even_a, paired_bits_ch_a);
            word_b <= weave(even_b, paired_bits_ch_b);
            flag_a <= range_flag_shared;
        end else if (rise) begin
            word_a <= sample_bits_ch_a;
            word_b <= sample_bits_ch_b;
            flag_a <= range_flag_ch_a;
            flag_b <= range_flag_ch_b;
        end
    end
endmodule

//--- tb/dafmt_tb_top.sv
// Self-checking bench for the dual-channel sample output formatter
`timescale 1ns/100ps
module dafmt_tb_top;
    logic        ref_clk, sys_rst, enc, par_prog, par_pin, ddr;
    logic        rga, rgb, wr, rd, irq, fct, fcc, ofa, ofb, ofs, term;
    logic [13:0] cva, cvb, sba, sbb, nb;
    logic [7:0]  addr;
    logic [31:0] wdata, rdata, v;
    logic [6:0]  pba, pbb;
    logic [2:0]  cur;
    int          err_total, n_checks;
    logic [13:0] tab [3] = '{14'h2000, 14'h1555, 14'h0AAA};

    dafmt_top uut (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .sample_strobe_true(enc), .conv_ch_a(cva), .conv_ch_b(cvb),
        .range_ch_a(rga), .range_ch_b(rgb), .par_prog_mode(par_prog),
        .par_mode_pin(par_pin), .reg_addr(addr), .reg_wdata(wdata),
        .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .irq(irq),
        .fwd_clock_true(fct), .fwd_clock_comp(fcc),
        .sample_bits_ch_a(sba), .sample_bits_ch_b(sbb),
        .range_flag_ch_a(ofa), .range_flag_ch_b(ofb),
        .paired_bits_ch_a(pba), .paired_bits_ch_b(pbb),
        .range_flag_shared(ofs), .lvds_term_en(term), .lvds_current(cur));

    dafmt_rx_model rx (.ref_clk(ref_clk), .ddr(ddr), .fwd_clock_true(fct),
        .sample_bits_ch_a(sba), .sample_bits_ch_b(sbb),
        .range_flag_ch_a(ofa), .range_flag_ch_b(ofb),
        .paired_bits_ch_a(pba), .paired_bits_ch_b(pbb),
        .range_flag_shared(ofs));

    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    // Encode strobe, 320 ns, unrelated in phase to the system clock
    initial begin
        enc = 1'b0;
        #7;
        forever #160 enc = ~enc;
    end

    task automatic check(input string name, input logic [31:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic close_out();
        $display("Checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge ref_clk);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge ref_clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask

    task automatic wait_enc(input int n);
        int k;
        logic p;
        k = 0;
        p = enc;
        for (int t = 0; t < n * 12 + 4 && k < n; t++) begin
            @(posedge ref_clk);
            if (enc && !p) k++;
            p = enc;
        end
        if (k < n) begin
            check("encode_wait", 0, 1);
            close_out();
        end
    endtask

    // New sample pair, held over more encodes than the pipeline
    task automatic put(input logic [13:0] x);
        for (int t = 0; t < 12 && enc; t++) @(posedge ref_clk);
        @(posedge ref_clk);
        cva <= x;
        cvb <= ~x;
        rga <= x[13];
        rgb <= ~x[0];
        wait_enc(dafmt_pkg::PIPE_DEPTH + 3);
    endtask

    task automatic chk_word(input logic [13:0] x);
        nb = ~x;
        check("word_a", rx.word_a, x);
        check("word_b", rx.word_b, nb);
        check("flag_a", rx.flag_a, x[13]);
        check("flag_b", rx.flag_b, !x[0]);
    endtask

    always @(negedge ref_clk) begin
        if (!sys_rst) check("clk_comp", fcc ^ fct, 1);
    end

    initial begin
        err_total = 0;
        n_checks = 0;
        sys_rst = 1'b1;
        {par_prog, par_pin, ddr, rga, rgb, wr, rd} = '0;
        {cva, cvb, addr, wdata} = '0;
        repeat (6) @(posedge ref_clk);
        sys_rst <= 1'b0;
        rd_reg(dafmt_pkg::OFF_CTRL, v);
        check("ctrl_rst", v, 32'h80);
        rd_reg(dafmt_pkg::OFF_STATUS, v);
        check("status_rst", v, 32'h0);
        rd_reg(dafmt_pkg::OFF_IRQ_MASK, v);
        check("mask_rst", v, 32'h0);
        rd_reg(8'h10, v);
        check("unmapped", v, 32'h0);
        check("current_rst", cur, 32'h4);
        $display("Test reset done");
        for (int m = 0; m < 3; m++) begin
            ddr <= (m != 0);
            wr_reg(dafmt_pkg::OFF_CTRL, m);
            rd_reg(dafmt_pkg::OFF_STATUS, v);
            check("mode", v, m);
            foreach (tab[i]) begin
                put(tab[i]);
                chk_word(tab[i]);
                if (m == 0) check("ddr_idle", {pba, pbb, ofs}, 0);
            end
        end
        $display("Test modes done");
        ddr <= 1'b0;
        for (int ph = 0; ph < 4; ph++) begin
            wr_reg(dafmt_pkg::OFF_CTRL, ph << dafmt_pkg::CTRL_PH_LSB);
            put(tab[ph % 3]);
            check("clk_lag", rx.lag, ph);
            chk_word(tab[ph % 3]);
        end
        $display("Test phase done");
        wr_reg(dafmt_pkg::OFF_CTRL, 32'hD2);
        repeat (2) @(posedge ref_clk);
        check("term", term, 1);
        check("current", cur, 32'h6);
        rd_reg(dafmt_pkg::OFF_CTRL, v);
        check("ctrl", v, 32'hD2);
        $display("Test lvds done");
        par_prog <= 1'b1;
        par_pin <= 1'b1;
        wr_reg(dafmt_pkg::OFF_CTRL, 32'h1);
        repeat (2) @(posedge ref_clk);
        rd_reg(dafmt_pkg::OFF_STATUS, v);
        check("par_lvds", v, 32'h6);
        par_pin <= 1'b0;
        repeat (3) @(posedge ref_clk);
        rd_reg(dafmt_pkg::OFF_STATUS, v);
        check("par_full", v, 32'h4);
        par_prog <= 1'b0;
        $display("Test parallel done");
        wr_reg(dafmt_pkg::OFF_IRQ_MASK, 32'h1);
        put(14'h1555);
        wr_reg(dafmt_pkg::OFF_IRQ_STAT, 32'h7);
        repeat (2) @(posedge ref_clk);
        check("irq_clear", irq, 0);
        put(14'h2000);
        check("irq_ovr", irq, 1);
        rd_reg(dafmt_pkg::OFF_IRQ_STAT, v);
        check("stat_ovr", v[dafmt_pkg::EVT_OVR_A], 1);
        wr_reg(dafmt_pkg::OFF_IRQ_MASK, 32'h0);
        repeat (2) @(posedge ref_clk);
        check("irq_masked", irq, 0);
        wr_reg(dafmt_pkg::OFF_IRQ_MASK, 32'h4);
        wait_enc(1);
        repeat (3) @(posedge ref_clk);
        wr_reg(dafmt_pkg::OFF_IRQ_STAT, 32'h7);
        @(negedge ref_clk);
        check("irq_idle", irq, 0);
        wait_enc(1);
        repeat (3) @(posedge ref_clk);
        @(negedge ref_clk);
        check("irq_sample", irq, 1);
        $display("Test interrupt done");
        close_out();
    end
endmodule
